// File: hw/hlb_consts.svh
`ifndef HLB_CONSTS_SVH
`define HLB_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Record layout and request codes
`define HLB_LOG_ID         8'h02
`define HLB_NSID_GLOBAL    32'hFFFFFFFF
`define HLB_LOG_BYTES      32
`define HLB_HDR_BYTES      8'h06
`define HLB_CW_SPARE       0
`define HLB_CW_TEMP        1
`define HLB_CW_RELIAB      2
`define HLB_CW_RDONLY      3
`define HLB_CW_BACKUP      4
`define HLB_PCT_MAX        8'h64
`define HLB_USED_CLAMP_IN  16'h00FE
`define HLB_USED_SAT       8'hFF
`define HLB_ERR_NONE       2'h0
`define HLB_ERR_LOGID      2'h1
`define HLB_ERR_NSID       2'h2

////////////////////////////////////////////////////////////////////////////////
// Register offsets, status bits and reset values
`define HLB_A_STATUS       8'h00
`define HLB_A_MASK         8'h04
`define HLB_A_SPARE        8'h08
`define HLB_A_TEMP_LIM     8'h0C
`define HLB_A_CONFIG       8'h10
`define HLB_A_REC0         8'h14
`define HLB_A_REC1         8'h18
`define HLB_ST_CRIT        0
`define HLB_ST_TEMP        1
`define HLB_ST_SPARE       2
`define HLB_ST_USED        3
`define HLB_RST_SPARE      8'h64
`define HLB_RST_THRESH     8'h0A
`define HLB_RST_OVER       16'hFFFF
`define HLB_RST_UNDER      16'h0000

////////////////////////////////////////////////////////////////////////////////
// Timing
`define HLB_HOUR_S         3600
`define HLB_CLK_HZ         40000000
`define HLB_HOUR_CYCLES    (64'(`HLB_HOUR_S) * 64'(`HLB_CLK_HZ))

`endif

// File: hw/hlb_pkg.sv
package hlb_pkg;

  typedef enum logic [1:0] {HLB_IDLE, HLB_SEND} hlb_fsm_t;

  typedef struct packed {
    hlb_fsm_t    fsm;
    logic [7:0]  idx;
    logic [47:0] snap;
    logic [7:0]  spare;
    logic [7:0]  thresh;
    logic [15:0] over_lim;
    logic [15:0] under_lim;
    logic        bk_present;
    logic [3:0]  sts;
    logic [3:0]  mask;
    logic [4:0]  crit_prev;
    logic [31:0] rdata;
    logic        irq;
    logic        aen;
    logic        lvalid;
    logic [7:0]  ldata;
    logic        llast;
    logic        done;
    logic [1:0]  err;
    logic        busy;
  } hlb_core_st_t;

  typedef struct packed {
    logic alarm;
  } hlb_temp_st_t;

  typedef struct packed {
    logic [39:0] cnt;
    logic [7:0]  used;
    logic        upd;
  } hlb_wear_st_t;

endpackage

// File: hw/hlb_if.sv
`timescale 1ns/100ps
interface hlb_if;
  logic [15:0] temp_k;
  logic [15:0] over_lim;
  logic [15:0] under_lim;
  logic        temp_alarm;
  logic [15:0] wear_est;
  logic        asleep;
  logic [7:0]  used_pct;
  logic        used_upd;

  modport core (output temp_k, over_lim, under_lim, wear_est, asleep,
                input  temp_alarm, used_pct, used_upd);
  modport temp (input  temp_k, over_lim, under_lim, output temp_alarm);
  modport wear (input  wear_est, asleep, output used_pct, used_upd);
endinterface

// File: hw/hlb_temp_mon.sv
`timescale 1ns/100ps
module hlb_temp_mon (
  input  wire logic sys_clk, // Core clock
  input  wire logic sys_rst, // Synchronous reset, high
  input  wire logic ce,      // Clock enable
  hlb_if.temp       bus      // Temperature and limits
);
  hlb_pkg::hlb_temp_st_t s_q;
  hlb_pkg::hlb_temp_st_t s_d;

  // Out of window on either side; equal to a limit is still in range
  always_comb begin
    s_d       = s_q;
    s_d.alarm = (bus.temp_k > bus.over_lim) || (bus.temp_k < bus.under_lim);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign bus.temp_alarm = s_q.alarm;
endmodule

// File: hw/hlb_wear_tracker.sv
`timescale 1ns/100ps
`include "hlb_consts.svh"
module hlb_wear_tracker #(
  parameter longint unsigned HOUR_CYCLES = `HLB_HOUR_CYCLES // Cycles per awake hour
) (
  input  wire logic sys_clk, // Core clock
  input  wire logic sys_rst, // Synchronous reset, high
  input  wire logic ce,      // Clock enable
  hlb_if.wear       bus      // Wear estimate and result
);
  hlb_pkg::hlb_wear_st_t s_q;
  hlb_pkg::hlb_wear_st_t s_d;

  // The hour counter is forty bits wide
  if (HOUR_CYCLES < 1 || HOUR_CYCLES > 64'h0000_00FF_FFFF_FFFF) begin : g_bad_hour
    $error("hlb_wear_tracker: HOUR_CYCLES out of range");
  end

  // Hour counter halts in sleep, so only awake time advances the refresh
  always_comb begin
    s_d     = s_q;
    s_d.upd = 1'b0;
    if (!bus.asleep) begin
      if (s_q.cnt == 40'(HOUR_CYCLES - 1)) begin
        s_d.cnt  = 40'h0;
        s_d.used = (bus.wear_est > `HLB_USED_CLAMP_IN) ? `HLB_USED_SAT : bus.wear_est[7:0];
        s_d.upd  = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 40'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign bus.used_pct = s_q.used;
  assign bus.used_upd = s_q.upd;
endmodule

// File: hw/health_log_builder.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "hlb_consts.svh"
module health_log_builder #(
  parameter int              LOG_BYTES   = `HLB_LOG_BYTES,  // Record length in bytes
  parameter longint unsigned HOUR_CYCLES = `HLB_HOUR_CYCLES // Cycles per awake hour
) (
  input  wire logic        sys_clk,         // Core clock, 40 MHz
  input  wire logic        sys_rst,         // Synchronous reset, high
  input  wire logic        ce,              // Clock enable, freezes state when low
  input  wire logic [7:0]  reg_addr,        // Register byte address
  input  wire logic [31:0] reg_wdata,       // Register write data
  input  wire logic        reg_wr,          // Write strobe
  input  wire logic        reg_rd,          // Read strobe
  output logic      [31:0] reg_rdata,       // Read data, cycle after strobe
  output logic             irq,             // Level interrupt
  output logic             aen,             // Warning event pulse
  input  wire logic [15:0] comp_temp_k,     // Composite temperature, kelvin
  input  wire logic        reliab_degraded, // Reliability degraded
  input  wire logic        media_read_only, // Media forced read-only
  input  wire logic        backup_failed,   // Volatile backup failed
  input  wire logic [15:0] wear_est,        // Raw life-used estimate
  input  wire logic        asleep,          // Controller in sleep state
  input  wire logic        req_valid,       // Record request
  input  wire logic [7:0]  req_log_id,      // Requested log identifier
  input  wire logic [31:0] req_nsid,        // Requested namespace
  output logic             req_busy,        // Record transfer in progress
  output logic             log_valid,       // Record byte valid
  output logic      [7:0]  log_data,        // Record byte
  output logic             log_last,        // Last record byte
  output logic             log_done,        // Request finished pulse
  output logic      [1:0]  log_err          // Finish code, with log_done
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // The byte index is eight bits wide and the header alone is six bytes
  if (LOG_BYTES < 6 || LOG_BYTES > 256) begin : g_bad_len
    $error("health_log_builder: LOG_BYTES must be 6 to 256");
  end

  // The hour counter in the wear tracker is forty bits wide
  if (HOUR_CYCLES < 1 || HOUR_CYCLES > 64'h0000_00FF_FFFF_FFFF) begin : g_bad_hour
    $error("health_log_builder: HOUR_CYCLES must fit in forty bits");
  end

  localparam logic [7:0] LAST_IDX = 8'(LOG_BYTES - 1);

  localparam hlb_pkg::hlb_core_st_t ST_RST = '{
    fsm:       hlb_pkg::HLB_IDLE,
    spare:     `HLB_RST_SPARE,
    thresh:    `HLB_RST_THRESH,
    over_lim:  `HLB_RST_OVER,
    under_lim: `HLB_RST_UNDER,
    default:   '0
  };

  ////////////////////////////////////////////////////////////////////////////////
  // State and helpers

  hlb_pkg::hlb_core_st_t s_q;
  hlb_pkg::hlb_core_st_t s_d;
  hlb_if                 u_if ();

  logic [4:0]  crit;
  logic [7:0]  crit_byte;
  logic [47:0] rec;
  logic        spare_low;
  logic [3:0]  events;
  logic [3:0]  sts_clr;
  // Register decode results
  logic [31:0] rd_word;
  logic        wr_mask;
  logic        wr_spare;
  logic        wr_lim;
  logic        wr_cfg;

  // Firmware may write any byte; the field is a percentage so cap at 100
  function automatic logic [7:0] pct_clamp(input logic [7:0] v);
    pct_clamp = (v > `HLB_PCT_MAX) ? `HLB_PCT_MAX : v;
  endfunction

  // Header byte by position; the reserved tail beyond it reads as zero
  // Kept apart from the state machine so the byte order sits in one place
  function automatic logic [7:0] hdr_byte(input logic [47:0] h, input logic [7:0] i);
    hdr_byte = 8'h00;
    if (i < `HLB_HDR_BYTES) begin
      case (i[2:0])
        3'h0: begin
          hdr_byte = h[7:0];
        end
        3'h1: begin
          hdr_byte = h[15:8];
        end
        3'h2: begin
          hdr_byte = h[23:16];
        end
        3'h3: begin
          hdr_byte = h[31:24];
        end
        3'h4: begin
          hdr_byte = h[39:32];
        end
        3'h5: begin
          hdr_byte = h[47:40];
        end
        default: begin
          hdr_byte = 8'h00;
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules

  // Limits cross to the monitor; alarm returns one cycle later
  assign u_if.temp_k    = comp_temp_k;
  assign u_if.over_lim  = s_q.over_lim;
  assign u_if.under_lim = s_q.under_lim;
  assign u_if.wear_est  = wear_est;
  assign u_if.asleep    = asleep;

  hlb_temp_mon u_temp (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .bus     (u_if.temp)
  );

  hlb_wear_tracker #(
    .HOUR_CYCLES (HOUR_CYCLES)
  ) u_wear (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .bus     (u_if.wear)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Live warning byte and record header

  // Each bit mirrors its present condition, the backup bit only while a backup is present; nothing is latched here
  always_comb begin
    spare_low                = (s_q.spare < s_q.thresh);
    crit                     = 5'h00;
    crit[`HLB_CW_SPARE]      = spare_low;
    crit[`HLB_CW_TEMP]       = u_if.temp_alarm;
    crit[`HLB_CW_RELIAB]     = reliab_degraded;
    crit[`HLB_CW_RDONLY]     = media_read_only;
    crit[`HLB_CW_BACKUP]     = s_q.bk_present & backup_failed;
  end

  // Upper warning bits are reserved and stay zero
  assign crit_byte = {3'h0, crit};

  // Byte order: warning, temperature low, high, spare, threshold, life used
  // Life used of 100 passes unchanged; failure is reported only via bit 2
  assign rec = {u_if.used_pct, s_q.thresh, s_q.spare, comp_temp_k, crit_byte};

  ////////////////////////////////////////////////////////////////////////////////
  // Event sources

  // Rising edges for the warning sources, so a standing condition raises one event; life used sets on each refresh
  always_comb begin
    events               = 4'h0;
    events[`HLB_ST_CRIT] = |(crit & ~s_q.crit_prev);
    events[`HLB_ST_TEMP] = crit[`HLB_CW_TEMP] & ~s_q.crit_prev[`HLB_CW_TEMP];
    events[`HLB_ST_SPARE] = spare_low & ~s_q.crit_prev[`HLB_CW_SPARE];
    events[`HLB_ST_USED] = u_if.used_upd;
  end

  // Read of status clears it; a new event in the same cycle still sets
  assign sts_clr = (reg_rd && reg_addr == `HLB_A_STATUS) ? 4'hF : 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Register write decode

  // One strobe per register; an unmapped write raises none and is dropped
  // Firmware owns spare, threshold and limits; no pin ever writes them
  always_comb begin
    wr_mask  = 1'b0;
    wr_spare = 1'b0;
    wr_lim   = 1'b0;
    wr_cfg   = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `HLB_A_MASK: begin
          wr_mask = 1'b1;
        end
        `HLB_A_SPARE: begin
          wr_spare = 1'b1;
        end
        `HLB_A_TEMP_LIM: begin
          wr_lim = 1'b1;
        end
        `HLB_A_CONFIG: begin
          wr_cfg = 1'b1;
        end
        default: begin
          // Unmapped offset: no strobe
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read decode

  // Decoded apart from the next state so the read path stays a plain mux
  // Record words show live values, not the snapshot of a transfer
  always_comb begin
    rd_word = 32'h0000_0000;
    case (reg_addr)
      `HLB_A_STATUS: begin
        rd_word = {28'h0, s_q.sts};
      end
      `HLB_A_MASK: begin
        rd_word = {28'h0, s_q.mask};
      end
      `HLB_A_SPARE: begin
        rd_word = {16'h0, s_q.thresh, s_q.spare};
      end
      `HLB_A_TEMP_LIM: begin
        rd_word = {s_q.under_lim, s_q.over_lim};
      end
      `HLB_A_CONFIG: begin
        rd_word = {31'h0, s_q.bk_present};
      end
      `HLB_A_REC0: begin
        rd_word = rec[31:0];
      end
      `HLB_A_REC1: begin
        rd_word = {16'h0, rec[47:32]};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d           = s_q;
    s_d.crit_prev = crit;
    s_d.aen       = events[`HLB_ST_CRIT];
    s_d.sts       = (s_q.sts & ~sts_clr) | events;
    s_d.rdata     = 32'h0000_0000;
    s_d.lvalid    = 1'b0;
    s_d.llast     = 1'b0;
    s_d.ldata     = 8'h00;
    s_d.done      = 1'b0;
    s_d.err       = `HLB_ERR_NONE;

    // Register writes, one decoded strobe each
    if (wr_mask) begin
      s_d.mask = reg_wdata[3:0];
    end
    if (wr_spare) begin
      s_d.spare  = pct_clamp(reg_wdata[7:0]);
      s_d.thresh = pct_clamp(reg_wdata[15:8]);
    end
    if (wr_lim) begin
      s_d.over_lim  = reg_wdata[15:0];
      s_d.under_lim = reg_wdata[31:16];
    end
    if (wr_cfg) begin
      s_d.bk_present = reg_wdata[0];
    end

    // Read data stand for one cycle only; unmapped offsets return zero
    if (reg_rd) begin
      s_d.rdata = rd_word;
    end

    s_d.irq = |(s_d.sts & s_d.mask);

    // Record transfer; header is frozen at request so bytes stay coherent
    case (s_q.fsm)
      hlb_pkg::HLB_IDLE: begin
        if (req_valid) begin
          if (req_log_id != `HLB_LOG_ID) begin
            s_d.done = 1'b1;
            s_d.err  = `HLB_ERR_LOGID;
          end else if (req_nsid != `HLB_NSID_GLOBAL) begin
            s_d.done = 1'b1;
            s_d.err  = `HLB_ERR_NSID;
          end else begin
            s_d.snap = rec;
            s_d.idx  = 8'h00;
            s_d.busy = 1'b1;
            s_d.fsm  = hlb_pkg::HLB_SEND;
          end
        end
      end
      hlb_pkg::HLB_SEND: begin
        s_d.lvalid = 1'b1;
        s_d.ldata  = hdr_byte(s_q.snap, s_q.idx);
        if (s_q.idx == LAST_IDX) begin
          s_d.llast = 1'b1;
          s_d.done  = 1'b1;
          s_d.busy  = 1'b0;
          s_d.fsm   = hlb_pkg::HLB_IDLE;
        end else begin
          s_d.idx = s_q.idx + 8'h01;
        end
      end
      default: begin
        s_d.fsm  = hlb_pkg::HLB_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= ST_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign reg_rdata = s_q.rdata;
  assign irq       = s_q.irq;
  assign aen       = s_q.aen;
  assign req_busy  = s_q.busy;
  assign log_valid = s_q.lvalid;
  assign log_data  = s_q.ldata;
  assign log_last  = s_q.llast;
  assign log_done  = s_q.done;
  assign log_err   = s_q.err;

endmodule

// File: tb/hlb_chk_sva.sv
`timescale 1ns/100ps
`include "hlb_consts.svh"
module hlb_chk (
  input wire logic        sys_clk,         // Clock
  input wire logic        sys_rst,         // Reset
  input wire logic        ce,              // Enable
  input wire logic        aen,             // Event
  input wire logic [15:0] comp_temp_k,     // Temperature
  input wire logic        media_read_only, // Read-only
  input wire logic        req_valid,       // Request
  input wire logic [7:0]  req_log_id,      // Log id
  input wire logic [31:0] req_nsid,        // Namespace
  input wire logic        req_busy,        // Busy
  input wire logic        log_valid,       // Byte valid
  input wire logic [7:0]  log_data,        // Byte
  input wire logic        log_last,        // Last byte
  input wire logic        log_done,        // Done
  input wire logic [1:0]  log_err          // Code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // A request is taken whenever the stream is idle
  logic tk;
  assign tk = ce && req_valid && !req_busy;
  sequence s_ok;
    tk && req_log_id == `HLB_LOG_ID && req_nsid == `HLB_NSID_GLOBAL;
  endsequence
  sequence s_stream;
    req_busy ##1 log_valid ##31 (log_last && log_done && log_err == `HLB_ERR_NONE && !req_busy);
  endsequence
  stream_ok_a: assert property (s_ok |=> s_stream)
    else $error("record stream malformed");
  id_bad_a: assert property (tk && req_log_id != `HLB_LOG_ID |=>
    log_done && log_err == `HLB_ERR_LOGID && !log_valid) else $error("bad log id not refused");
  ns_bad_a: assert property (tk && req_log_id == `HLB_LOG_ID && req_nsid != `HLB_NSID_GLOBAL
    |=> log_done && log_err == `HLB_ERR_NSID) else $error("bad namespace not refused");
  temp_bytes_a: assert property (s_ok |-> ##3 (log_data == $past(comp_temp_k[7:0], 3))
    ##1 (log_data == $past(comp_temp_k[15:8], 4))) else $error("temperature bytes wrong");
  cw_high_a: assert property (log_valid && !$past(log_valid) |-> log_data[7:5] == 3'h0)
    else $error("warning high bits set");
  tail_zero_a: assert property (log_last |-> log_data == 8'h00)
    else $error("reserved tail byte nonzero");
  ro_event_a: assert property ($rose(media_read_only) |-> ##[1:3] aen)
    else $error("no event on read-only");
  // Only a condition steady across the snapshot is judged
  cw_ro_a: assert property (tk && req_log_id == `HLB_LOG_ID
    && req_nsid == `HLB_NSID_GLOBAL && $past(media_read_only) == media_read_only
    && $past(media_read_only, 2) == media_read_only |-> ##2 log_data[3] == media_read_only)
    else $error("read-only bit wrong");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind health_log_builder hlb_chk u_chk (.sys_clk, .sys_rst, .ce, .aen, .comp_temp_k,
  .media_read_only, .req_valid, .req_log_id, .req_nsid, .req_busy, .log_valid, .log_data,
  .log_last, .log_done, .log_err);

// File: tb/hlb_host_model.sv
`timescale 1ns/100ps
module hlb_host_model (
  input  wire logic        sys_clk,              // Clock
  input  wire logic        sys_rst,              // Reset
  input  wire logic        go,                   // Start request
  input  wire logic [7:0]  id,                   // Log id asked
  input  wire logic [31:0] ns,                   // Namespace asked
  input  wire logic        req_busy,             // Busy
  input  wire logic        log_valid,            // Byte valid
  input  wire logic [7:0]  log_data,             // Byte
  input  wire logic        log_done,             // Done
  input  wire logic [1:0]  log_err,              // Code
  output logic             req_valid = 1'b0,     // Request
  output logic      [7:0]  req_log_id = 8'h00,   // Log id
  output logic      [31:0] req_nsid = 32'h0,     // Namespace
  output logic      [7:0]  rec [32],             // Bytes seen
  output logic      [6:0]  nb,                   // Byte count
  output logic      [1:0]  err,                  // Code seen
  output logic             fin                   // Finished
);
  // Request held until idle is seen, then lines scrambled so stale values never pass
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      req_valid <= 1'b0;
      fin       <= 1'b0;
    end else if (go) begin
      req_valid  <= 1'b1;
      req_log_id <= id;
      req_nsid   <= ns;
      nb         <= 7'h00;
      fin        <= 1'b0;
    end else begin
      if (req_valid && !req_busy) begin
        req_valid  <= 1'b0;
        req_log_id <= ~req_log_id;
        req_nsid   <= ~req_nsid;
      end
      if (log_valid) begin
        rec[nb[4:0]] <= log_data;
        nb           <= nb + 7'h01;
      end
      if (log_done) begin
        fin <= 1'b1;
        err <= log_err;
      end
    end
  end
endmodule

// File: tb/health_log_builder_bench.sv
`timescale 1ns/100ps
`include "hlb_consts.svh"
module health_log_builder_bench;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq;
  logic        reliab = 1'b0, rd_only = 1'b0, bk_fail = 1'b0, asleep = 1'b0, ce = 1'b1;
  logic        req_valid, req_busy, log_valid, log_done, go = 1'b0, fin;
  logic [7:0]  reg_addr = 8'h00, req_log_id, log_data, h_id = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, req_nsid, h_ns = 32'h0, d;
  logic [15:0] temp = 16'h012C, wear = 16'h0140;
  logic [1:0]  log_err, h_err;
  logic [6:0]  h_nb;
  logic [7:0]  rec [32];
  logic [47:0] hdr = 48'hFF0A05012C1F;
  int          n_mismatch = 0, n_compared = 0;

  always #12.5 sys_clk = ~sys_clk;

  // Short hour so wear refresh is seen within the run
  health_log_builder #(.HOUR_CYCLES(10)) dut (.sys_clk, .sys_rst, .ce, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .aen(), .comp_temp_k(temp),
    .reliab_degraded(reliab), .media_read_only(rd_only), .backup_failed(bk_fail),
    .wear_est(wear), .asleep, .req_valid, .req_log_id, .req_nsid, .req_busy, .log_valid,
    .log_data, .log_last(), .log_done, .log_err);
  hlb_host_model hst (.sys_clk, .sys_rst, .go, .id(h_id), .ns(h_ns), .req_busy, .log_valid,
    .log_data, .log_done, .log_err, .req_valid, .req_log_id, .req_nsid, .rec, .nb(h_nb),
    .err(h_err), .fin);

  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data only stand in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task rec0(input logic [31:0] e);
    repeat (3) @(posedge sys_clk);
    rd(`HLB_A_REC0);
    chk("rec0", d, e);
  endtask
  task req(input logic [7:0] i, input logic [31:0] n, input logic [1:0] e);
    int k;
    @(posedge sys_clk);
    h_id <= i;
    h_ns <= n;
    go   <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    // The model clears its finish flag on this edge; poll only once that has landed
    @(posedge sys_clk);
    for (k = 0; k < 50 && fin !== 1'b1; k++) @(posedge sys_clk);
    if (fin !== 1'b1) begin
      n_mismatch++;
      report_and_stop;
    end else begin
      chk("err", h_err, e);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`HLB_A_REC1);
    chk("used0", d, 32'h0000000A);
    rd(`HLB_A_SPARE);
    chk("spare", d, 32'h00000A64);
    rd(`HLB_A_TEMP_LIM);
    chk("lim", d, 32'h0000FFFF);
    rd(8'h1C);
    chk("unmapped", d, 32'h0);
    wr(`HLB_A_MASK, 32'h1);
    rd(`HLB_A_STATUS);
    // Warnings pile up one by one; several bits stand together
    wr(`HLB_A_SPARE, 32'h00000A05);
    rec0(32'h05012C01);
    chk("irq", irq, 32'h1);
    rd(`HLB_A_STATUS);
    chk("sts", d & 32'h7, 32'h5);
    repeat (3) @(posedge sys_clk);
    chk("irq", irq, 32'h0);
    wr(`HLB_A_TEMP_LIM, 32'h00000120);
    rec0(32'h05012C03);
    rd(`HLB_A_STATUS);
    chk("sts", d & 32'h3, 32'h3);
    @(posedge sys_clk);
    reliab <= 1'b1;
    rec0(32'h05012C07);
    @(posedge sys_clk);
    rd_only <= 1'b1;
    rec0(32'h05012C0F);
    @(posedge sys_clk);
    bk_fail <= 1'b1;
    rec0(32'h05012C0F);
    wr(`HLB_A_CONFIG, 32'h1);
    rec0(32'h05012C1F);
    req(`HLB_LOG_ID, `HLB_NSID_GLOBAL, `HLB_ERR_NONE);
    chk("count", h_nb, 32'd32);
    for (k = 0; k < 32; k++) chk("byte", rec[k], k < 6 ? hdr[8*k+:8] : 8'h00);
    // Conditions clear; spare clamps; under-limit alarm
    @(posedge sys_clk);
    reliab  <= 1'b0;
    rd_only <= 1'b0;
    bk_fail <= 1'b0;
    wr(`HLB_A_SPARE, 32'h00000AC8);
    rd(`HLB_A_SPARE);
    chk("clamp", d, 32'h00000A64);
    // A write while the clock enable is low must not land
    ce <= 1'b0;
    wr(`HLB_A_SPARE, 32'h00000A05);
    ce <= 1'b1;
    rd(`HLB_A_SPARE);
    chk("frozen", d, 32'h00000A64);
    wr(`HLB_A_TEMP_LIM, 32'h0130FFFF);
    rec0(32'h64012C02);
    wr(`HLB_A_TEMP_LIM, 32'h0000FFFF);
    rec0(32'h64012C00);
    wr(`HLB_A_MASK, 32'h0);
    rd(`HLB_A_STATUS);
    @(posedge sys_clk);
    reliab <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("irq", irq, 32'h0);
    rd(`HLB_A_STATUS);
    chk("sts", d & 32'h1, 32'h1);
    @(posedge sys_clk);
    reliab <= 1'b0;
    req(8'h03, `HLB_NSID_GLOBAL, `HLB_ERR_LOGID);
    chk("count", h_nb, 32'd0);
    req(`HLB_LOG_ID, 32'h1, `HLB_ERR_NSID);
    req(8'h03, 32'h1, `HLB_ERR_LOGID);
    // Sleep halts the hour; 100 is no failure; large values saturate
    @(posedge sys_clk);
    asleep <= 1'b1;
    wear   <= 16'h0064;
    repeat (30) @(posedge sys_clk);
    rd(`HLB_A_REC1);
    chk("sleep", d, 32'h0000FF0A);
    @(posedge sys_clk);
    asleep <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rd(`HLB_A_REC1);
    chk("used", d, 32'h0000640A);
    rec0(32'h64012C00);
    for (k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      wear <= 16'h00FE + 16'(k);
      repeat (12) @(posedge sys_clk);
      rd(`HLB_A_REC1);
      chk("sat", d, {16'h0, k == 0 ? 8'hFE : 8'hFF, 8'h0A});
    end
    report_and_stop;
  end
endmodule
